// File: hdl/overhead_regs.svh
// register map, field positions and frame constants of the overhead inserter
// Behaviour
// - remote alarm bit follows remote defect request within 5 ms both ways.
// - even frames carry 0011011 in bits 2 to 8 of slot zero.
// - odd frames carry 1 in bit 2 of slot zero.
// - checksum mode off puts constant 1 in bit 1 of slot zero.
// - checksum mode on or automatic builds 16-frame multiframe in bit 1.
// - multiframe alignment 001011 goes in bit 1 of frames 1,3,5,7,9,11.
// - each multiframe carries exactly two far-end error bits, made here.
// - far-end error bit is 1 unless a pending error request is reported.
// - each true error request clears one far-end error bit within 1 second.
// - four-bit checksum of each submultiframe goes into the next one.
// - all-ones output within 250 us of request, normal data within 250 us after.
// - an undriven all-ones request counts as inactive; here it is not pulled low, so its x stalls the level crossing and the link side keeps its old levels.
// - without checksum mode, double frames of two 256-bit frames.
// - with checksum mode, multiframes of sixteen 256-bit frames.
// - the national spare bits, and a quality message in them, pass unchanged.
`ifndef OVERHEAD_REGS_SVH
`define OVERHEAD_REGS_SVH
// =====================================================================
// register offsets and fields
`define CTRL_OFFSET 4'h0
`define STATUS_OFFSET 4'h4
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 1
`define CTRL_AIS_BIT 2
`define CTRL_RESET 3'h0
`define STATUS_CNT_LSB 0
`define STATUS_CNT_MSB 7
`define STATUS_BUSY_BIT 8
// =====================================================================
// frame layout and timing bounds
`define FRAME_BITS 9'h100
`define LAST_BIT 8'hff
`define LAST_FRAME 4'hf
`define FRAME_ALIGN_WORD 7'h1b
`define MULTIFRAME_ALIGN_WORD 6'h0b
`define CRC_POLY 4'h3
`define RDI_MAX_US 5000
`define AIS_MAX_US 250
`define REI_MAX_US 1000000
`endif

// File: hdl/overhead_pkg.sv
// types shared by the overhead inserter
package overhead_pkg;
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_ON = 2'h1,
        MODE_AUTO = 2'h2
    } checksum_mode_t;

    // levels carried from the bus domain to the link domain
    typedef struct packed {
        logic req_tgl;
        logic all_ones;
        logic defect;
        logic [1:0] mode;
    } cross_t;

    typedef struct packed {
        logic [1:0] ctrl_mode;
        logic ctrl_ais;
        logic [7:0] pend_cnt;
        logic req_tgl;
        logic busy;
        logic [2:0] ack_sync;
        logic ack_s;
        cross_t to_link;
        logic [31:0] dat;
        logic ack;
    } sys_state_t;

    typedef struct packed {
        cross_t sync1;
        cross_t sync2;
        cross_t sync3;
        cross_t lvl;
        logic [7:0] bitpos;
        logic [3:0] frm;
        logic [3:0] crc_acc;
        logic [3:0] crc_tx;
        logic ack_tgl;
        logic dout;
        logic fs_out;
        logic mfs_out;
    } link_state_t;
endpackage

// File: hdl/overhead_inserter.sv
// frame overhead inserter for a 2048 kbit/s path, source direction
`timescale 1ns/100ps
`default_nettype none
`include "overhead_regs.svh"

module overhead_inserter (
    // bus clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // requests from sink and adaptation logic, sys_clk domain
    input wire logic remote_defect_request,
    input wire logic remote_error_request,
    input wire logic all_ones_insert_request,
    // payload from the client adaptation, link domain
    input wire logic payload_clock_in,
    input wire logic payload_data_in,
    input wire logic payload_frame_start_in,
    input wire logic payload_multiframe_start_in,
    // framed stream to the server layer
    output logic framed_clock_out,
    output logic framed_data_out,
    output logic framed_frame_start_out,
    output logic framed_multiframe_start_out
);

    // =====================================================================
    // bus domain
    overhead_pkg::sys_state_t sq;
    overhead_pkg::sys_state_t sd;
    logic wb_hit;
    logic ack_stable;

    overhead_pkg::link_state_t lq;
    overhead_pkg::link_state_t ld;

    assign wb_hit = wb_cyc_i & wb_stb_i & ~sq.ack;

    // register access, error request counting and handshake to the link
    always_comb begin
        sd = sq;
        ack_stable = sq.ack_s;
        // ack toggle from the link passes three flops
        sd.ack_sync = {sq.ack_sync[1:0], lq.ack_tgl};
        if (sq.ack_sync[1] == sq.ack_sync[2]) begin
            ack_stable = sq.ack_sync[2];
        end
        sd.ack_s = ack_stable;
        // one-cycle ack, dropped in the cycle after it
        sd.ack = wb_hit;
        sd.dat = 32'h0;
        if (wb_hit && !wb_we_i) begin
            case (wb_adr_i)
                `CTRL_OFFSET: begin
                    sd.dat[`CTRL_MODE_MSB:`CTRL_MODE_LSB] = sq.ctrl_mode;
                    sd.dat[`CTRL_AIS_BIT] = sq.ctrl_ais;
                end
                `STATUS_OFFSET: begin
                    sd.dat[`STATUS_CNT_MSB:`STATUS_CNT_LSB] = sq.pend_cnt;
                    sd.dat[`STATUS_BUSY_BIT] = sq.busy;
                end
                default: begin
                    sd.dat = 32'h0;
                end
            endcase
        end
        if (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == `CTRL_OFFSET) begin
            sd.ctrl_mode = wb_dat_i[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
            sd.ctrl_ais = wb_dat_i[`CTRL_AIS_BIT];
        end
        // a finished handshake and a new request in one cycle cancel out
        if (sq.busy && ack_stable == sq.req_tgl) begin
            sd.busy = 1'b0;
            if (!remote_error_request) begin
                sd.pend_cnt = sq.pend_cnt - 8'h1;
            end
        end else if (remote_error_request && sq.pend_cnt != 8'hff) begin
            sd.pend_cnt = sq.pend_cnt + 8'h1;
        end
        // one request at a time crosses, so none is lost in the toggle
        if (!sq.busy && sq.pend_cnt != 8'h0) begin
            sd.req_tgl = ~sq.req_tgl;
            sd.busy = 1'b1;
        end
        sd.to_link.req_tgl = sd.req_tgl;
        sd.to_link.mode = sq.ctrl_mode;
        sd.to_link.defect = remote_defect_request;
        // an input tied low or left at its reset level never forces ones
        sd.to_link.all_ones = all_ones_insert_request | sq.ctrl_ais;
    end

    // bus domain registers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sq <= '0;
        end else begin
            sq <= sd;
        end
    end

    assign wb_dat_o = sq.dat;
    assign wb_ack_o = sq.ack;

    // =====================================================================
    // link domain reset: asserted at once, released on the link clock
    logic [1:0] link_rst_q;
    logic link_rst;

    always_ff @(posedge payload_clock_in or posedge reset) begin
        if (reset) begin
            link_rst_q <= 2'h3;
        end else begin
            link_rst_q <= {link_rst_q[0], 1'b0};
        end
    end

    assign link_rst = link_rst_q[1];

    // =====================================================================
    // link domain framing
    logic [7:0] pos;
    logic [3:0] frm;
    logic new_frame;
    logic odd;
    logic crc_on;
    logic smf_start;
    logic [3:0] tx_crc;
    logic obit;
    logic crc_in;
    logic fb;
    logic rei_pend;
    // patterns held as named constants, since a bit of a bare literal cannot be selected
    localparam logic [6:0] FAW_PATTERN = `FRAME_ALIGN_WORD;
    localparam logic [5:0] MFA_PATTERN = `MULTIFRAME_ALIGN_WORD;

    // position counters, overhead insertion and checksum
    always_comb begin
        ld = lq;
        ld.sync1 = sq.to_link;
        ld.sync2 = lq.sync1;
        ld.sync3 = lq.sync2;
        // a level counts once the second and third stages agree
        if (lq.sync2 == lq.sync3) begin
            ld.lvl = lq.sync3;
        end
        crc_on = lq.lvl.mode != overhead_pkg::MODE_OFF;
        rei_pend = lq.lvl.req_tgl != lq.ack_tgl;
        // frame start input realigns, otherwise free run
        new_frame = payload_frame_start_in || lq.bitpos == `LAST_BIT;
        pos = payload_frame_start_in ? 8'h0 : lq.bitpos + 8'h1;
        frm = lq.frm;
        if (payload_multiframe_start_in) begin
            frm = 4'h0;
        end else if (new_frame) begin
            frm = lq.frm + 4'h1;
        end
        odd = frm[0];
        smf_start = pos == 8'h0 && frm[2:0] == 3'h0;
        tx_crc = smf_start ? lq.crc_acc : lq.crc_tx;
        obit = payload_data_in;
        crc_in = payload_data_in;
        if (pos == 8'h0) begin
            if (!crc_on) begin
                obit = 1'b1;
            end else if (!odd) begin
                obit = tx_crc[2'h3 - frm[2:1]];
            end else if (frm < 4'hc) begin
                obit = MFA_PATTERN[3'h5 - frm[3:1]];
            end else begin
                obit = ~rei_pend;
                if (rei_pend) begin
                    ld.ack_tgl = ~lq.ack_tgl;
                end
            end
            crc_in = (crc_on && !odd) ? 1'b0 : obit;
        end else if (pos < 8'h8) begin
            if (!odd) begin
                obit = FAW_PATTERN[3'h7 - pos[2:0]];
            end else if (pos == 8'h1) begin
                obit = 1'b1;
            end else if (pos == 8'h2) begin
                obit = lq.lvl.defect;
            end
            crc_in = obit;
        end
        // serial divide by x^4+x+1, restarted each submultiframe
        fb = (smf_start ? 1'b0 : lq.crc_acc[3]) ^ crc_in;
        if (smf_start) begin
            ld.crc_acc = fb ? `CRC_POLY : 4'h0;
        end else begin
            ld.crc_acc = {lq.crc_acc[2:0], 1'b0} ^ (fb ? `CRC_POLY : 4'h0);
        end
        ld.crc_tx = tx_crc;
        ld.bitpos = pos;
        ld.frm = frm;
        // all ones replace everything, overhead included
        ld.dout = lq.lvl.all_ones ? 1'b1 : obit;
        ld.fs_out = pos == 8'h0;
        ld.mfs_out = pos == 8'h0 && frm == 4'h0;
    end

    // link domain registers
    always_ff @(posedge payload_clock_in or posedge link_rst) begin
        if (link_rst) begin
            lq <= '0;
        end else begin
            lq <= ld;
        end
    end

    // output clock is the payload clock itself; data changes one edge later
    assign framed_clock_out = payload_clock_in;
    assign framed_data_out = lq.dout;
    assign framed_frame_start_out = lq.fs_out;
    assign framed_multiframe_start_out = lq.mfs_out;

endmodule // overhead_inserter
`default_nettype wire

// File: bench/payload_source.sv
// payload source model: random bits with frame and multiframe starts
`timescale 1ns/100ps
`default_nettype none
module payload_source (
    // link clock and reset
    input wire logic clk,
    input wire logic reset,
    // payload stream
    output logic data,
    output logic fs,
    output logic mfs
);
    logic [11:0] cnt;
    int seed = 24;
    // sole driver of the payload lines: 256 bits a frame, 16 frames a multiframe
    assign fs = cnt[7:0] == 8'h00;
    assign mfs = cnt == 12'h000;
    // first start comes late so the link side is already out of reset
    always @(posedge clk or posedge reset) begin
        if (reset)
            cnt <= 12'hff0;
        else
            cnt <= cnt + 12'h001;
        data <= reset ? 1'b0 : 1'($random(seed));
    end
endmodule // payload_source
`default_nettype wire

// File: bench/overhead_inserter_chk.sv
// concurrent checks on the overhead inserter ports
`timescale 1ns/100ps
`default_nettype none
module overhead_inserter_chk (
    // clocks and reset
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic payload_clock_in,
    // bus handshake
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    // frame timing
    input wire logic payload_frame_start_in,
    input wire logic payload_multiframe_start_in,
    input wire logic framed_clock_out,
    input wire logic framed_frame_start_out,
    input wire logic framed_multiframe_start_out
);
    // ====================================================================
    // bus answer: one pulse one cycle after the request, data zero between
    AST_ACK_NEXT: assert property (@(posedge sys_clk) disable iff (reset)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    AST_ACK_ONE: assert property (@(posedge sys_clk) disable iff (reset)
        wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_DAT_IDLE: assert property (@(posedge sys_clk) disable iff (reset)
        !wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data not idle");
    // link timing: starts follow the payload by one edge, clock passes through
    AST_FS_DELAY: assert property (@(posedge payload_clock_in) disable iff (reset)
        payload_frame_start_in |=> framed_frame_start_out) else $error("frame start");
    AST_MFS_DELAY: assert property (@(posedge payload_clock_in) disable iff (reset)
        payload_multiframe_start_in |=> framed_multiframe_start_out) else $error("mf start");
    AST_MFS_IN_FS: assert property (@(posedge payload_clock_in) disable iff (reset)
        framed_multiframe_start_out |-> framed_frame_start_out) else $error("mf off frame");
    AST_FS_GAP: assert property (@(posedge payload_clock_in) disable iff (reset)
        framed_frame_start_out |=> !framed_frame_start_out [*8]) else $error("frame short");
    AST_CLK_PASS: assert property (@(posedge sys_clk) disable iff (reset)
        framed_clock_out == payload_clock_in) else $error("clock not passed");
endmodule // overhead_inserter_chk
bind overhead_inserter overhead_inserter_chk chk (.sys_clk, .reset, .payload_clock_in,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o, .payload_frame_start_in,
    .payload_multiframe_start_in, .framed_clock_out, .framed_frame_start_out,
    .framed_multiframe_start_out);
`default_nettype wire

// File: bench/overhead_inserter_bench.sv
// self-checking bench of the overhead inserter
`timescale 1ns/100ps
`default_nettype none
module overhead_inserter_bench;
    logic sys_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, payload_clock_in;
    logic [3:0] wb_adr_i, wb_sel_i, acc, cref, f;
    logic [31:0] wb_dat_i, wb_dat_o, r;
    logic remote_defect_request, remote_error_request, all_ones_insert_request;
    logic payload_data_in, payload_frame_start_in, payload_multiframe_start_in;
    logic framed_clock_out, framed_data_out, framed_frame_start_out, framed_multiframe_start_out;
    logic on, ais, alarm, chk, cok, cfull, b, fb, cpos, last;
    logic [7:0] p;
    logic [6:0] faw = 7'h1b;
    logic [5:0] mfa = 6'h0b;
    int miscompares, compares, ez, seed, sent;
    overhead_inserter DUT (.sys_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .remote_defect_request,
        .remote_error_request, .all_ones_insert_request, .payload_clock_in, .payload_data_in,
        .payload_frame_start_in, .payload_multiframe_start_in, .framed_clock_out,
        .framed_data_out, .framed_frame_start_out, .framed_multiframe_start_out);
    payload_source src (.clk(payload_clock_in), .reset, .data(payload_data_in),
        .fs(payload_frame_start_in), .mfs(payload_multiframe_start_in));
    // ====================================================================
    // clocks: link clock offset so the two never share an edge
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        payload_clock_in = 1'b0;
        #7;
        forever #15 payload_clock_in = ~payload_clock_in;
    end
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task complete_run;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // classic single cycle, held until ack is seen at a rising edge
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask
    // checks pause for one frame while the new levels cross into the link side
    task phase(input logic [2:0] ctl, input logic rdi, input logic aisp, input int n);
        {chk, cfull} = 2'h0;
        wb(1'b1, 4'h0, {29'h0, ctl});
        remote_defect_request <= rdi;
        all_ones_insert_request <= aisp;
        repeat (256) @(negedge payload_clock_in);
        {on, ais, alarm, chk} = {ctl[1:0] != 2'h0, ctl[2] | aisp, rdi, 1'b1};
        repeat (n * 256) @(negedge payload_clock_in);
    endtask
    // decoder of the framed stream; the output bit follows the input by one edge
    always @(negedge payload_clock_in) begin
        b = framed_data_out;
        p = framed_frame_start_out ? 8'h00 : p + 8'h01;
        f = framed_multiframe_start_out ? 4'h0 : f + 4'(framed_frame_start_out);
        cpos = on && p == 8'h00 && !f[0];
        if (cpos && f[2:0] == 3'h0)
            {cref, cok, acc, cfull} = {acc, cfull, 4'h0, chk && !ais};
        fb = (cpos ? 1'b0 : b) ^ acc[3];
        acc = {acc[2:0], 1'b0} ^ (fb ? 4'h3 : 4'h0);
        // only odd frames 13 and 15 carry far-end error bits; frame 14 holds a checksum bit
        if (on && p == 8'h00 && f > 4'hc && f[0] && b === 1'b0)
            ez++;
        if (chk) begin
            if (ais)
                cmp(32'(b), 32'h1);
            else if (cpos)
                cmp(32'(b), cok ? 32'(cref[3 - f[2:1]]) : 32'(b));
            else if (on && p == 8'h00 && f > 4'hc)
                cmp(32'(b), (ez <= sent) ? 32'(b) : 32'h1);
            else if (p == 8'h00)
                cmp(32'(b), on ? 32'(mfa[5 - f[3:1]]) : 32'h1);
            else if (p > 8'h07 || (f[0] && p > 8'h02))
                cmp(32'(b), 32'(last));
            else if (!f[0])
                cmp(32'(b), 32'(faw[7 - p]));
            else
                cmp(32'(b), p == 8'h01 ? 32'h1 : 32'(alarm));
        end
        last = payload_data_in;
    end
    initial begin
        {seed, miscompares, compares, ez, sent} = {32'd24, 128'h0};
        {p, f, acc} = 16'h0;
        {reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {8'h80, 4'hf, 32'h0};
        {remote_defect_request, remote_error_request, all_ones_insert_request} = 3'h0;
        {on, ais, alarm, chk, cok, cfull, last} = 7'h0;
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        wb(1'b0, 4'h0, 32'h0);
        cmp(r, 32'h0); // reset value of control
        wb(1'b1, 4'h8, 32'h7);
        wb(1'b0, 4'h8, 32'h0);
        cmp(r, 32'h0); // unmapped place
        phase(3'h0, 1'b0, 1'b0, 2);
        phase(3'h0, 1'b1, 1'b0, 2);
        phase(3'h1, 1'b0, 1'b0, 32);
        cmp(ez, 0);
        repeat (2) begin
            @(posedge sys_clk);
            remote_error_request <= 1'b1;
            sent++;
            @(posedge sys_clk);
            remote_error_request <= 1'b0;
            repeat (8'($random(seed))) @(posedge sys_clk);
        end
        phase(3'h2, 1'b0, 1'b0, 32);
        cmp(ez, 2);
        phase(3'h4, 1'b0, 1'b0, 2);
        phase(3'h0, 1'b0, 1'b1, 2);
        phase(3'h1, 1'b0, 1'b0, 2);
        complete_run;
    end
    // hang guard, well beyond the expected run of some 625 us
    initial begin
        #900000;
        miscompares++;
        complete_run;
    end
endmodule // overhead_inserter_bench
`default_nettype wire
